// >>> design/stc_timer.sv
// sixteen bit timer counter with control, interrupt and byte access
// How it works
// [RQ1] the count is two readable and writable bytes, low and high.
// [RQ2] rolling over from FFFF to 0000 sets the sticky overflow flag.
// [RQ3] the special event trigger from the capture compare unit clears the count.
// [RQ4] control bit 0 runs the counter when set and stops it when clear.
// [RQ5] control bit 7 makes the two bytes one atomic sixteen bit access via a high buffer.
// [RQ6] control bit 6 is read only and shows whether the system clock comes from this oscillator.
// [RQ7] control bit 3 enables the timer oscillator, clearing it shuts the oscillator down.
// [RQ8] control bit 1 selects rising edges on the count pin, else the clock divided by four.
// [RQ9] control bits 5 and 4 prescale the selected clock by 1, 2, 4 or 8.
// [RQ10] with the pin selected bit 2 bypasses synchronisation, else it is ignored.
`timescale 1ns/100ps
`default_nettype none
module stc_timer #(
  parameter int PRE_W = 3
) (
  input  wire logic       CLK,
  input  wire logic       RSTN,
  input  wire logic [3:0] ADDR,
  input  wire logic [7:0] WDATA,
  input  wire logic       WR,
  input  wire logic       RD,
  output logic      [7:0] RDATA,
  input  wire logic       EXT_COUNT_PIN,
  input  wire logic       SPECIAL_EVENT,
  input  wire logic       SYSCLK_FROM_TIMER_OSC,
  output logic            TIMER_OSC_ENABLE,
  output logic            IRQ
);
  // ==========================================================
  // state
  logic [7:0]       ctrl_reg, ctrl_next;
  logic [15:0]      count_reg, count_next;
  logic [7:0]       hbuf_reg, hbuf_next;
  logic [1:0]       idiv_reg, idiv_next;
  logic [PRE_W-1:0] pre_reg, pre_next;
  logic [1:0]       stat_reg, stat_next;
  logic [1:0]       mask_reg, mask_next;
  logic [7:0]       rdata_reg, rdata_next;
  logic             ext_rise, src_tick, pre_tick, ovf;
  logic             wr_ctl, wr_lo, wr_hi, wr_st, wr_mk;
  logic             ext_mode;
  logic [PRE_W-1:0] pre_lim;

  function automatic logic hit(input logic [3:0] a, input logic [3:0] o, input logic s);
    hit = s && (a == o);
  endfunction

  assign ext_mode = ctrl_reg[stc_pkg::BIT_CLK_SEL];

  // ==========================================================
  // pin edge detection, synchroniser bypassable in pin mode only
  stc_edge_sync stc_edge_sync_i (
    .clk    (CLK),
    .rst_n  (RSTN),
    .pin    (EXT_COUNT_PIN),
    .bypass (ctrl_reg[stc_pkg::BIT_SYNC_BYP] & ext_mode), // RQ10
    .rise   (ext_rise)
  );

  // ==========================================================
  // write decode
  always_comb begin
    wr_ctl = hit(ADDR, stc_pkg::OFF_CONTROL, WR);
    wr_lo  = hit(ADDR, stc_pkg::OFF_COUNT_LO, WR);
    wr_hi  = hit(ADDR, stc_pkg::OFF_COUNT_HI, WR);
    wr_st  = hit(ADDR, stc_pkg::OFF_IRQ_STAT, WR);
    wr_mk  = hit(ADDR, stc_pkg::OFF_IRQ_MASK, WR);
  end

  // ==========================================================
  // clock source, prescaler and counter
  always_comb begin
    idiv_next = idiv_reg + 2'h1;
    src_tick  = ext_mode ? ext_rise : (idiv_reg == stc_pkg::INT_DIV); // RQ8
    pre_lim   = PRE_W'((1 << ctrl_reg[stc_pkg::BIT_PRE_HI:stc_pkg::BIT_PRE_LO]) - 1); // RQ9
    pre_next  = pre_reg;
    pre_tick  = 1'b0;
    if (ctrl_reg[stc_pkg::BIT_RUN] && src_tick) begin // RQ4
      if (pre_reg >= pre_lim) begin
        pre_next = '0;
        pre_tick = 1'b1;
      end else begin
        pre_next = pre_reg + PRE_W'(1);
      end
    end
    count_next = count_reg;
    ovf        = 1'b0;
    if (pre_tick) begin
      count_next = count_reg + 16'h0001;
      ovf        = (count_reg == stc_pkg::COUNT_MAX); // RQ2
    end
    hbuf_next = hbuf_reg;
    if (wr_lo) begin // RQ1
      if (ctrl_reg[stc_pkg::BIT_WIDE])
        count_next = {hbuf_reg, WDATA}; // RQ5
      else
        count_next[7:0] = WDATA;
    end
    if (wr_hi) begin
      if (ctrl_reg[stc_pkg::BIT_WIDE])
        hbuf_next = WDATA; // RQ5
      else
        count_next[15:8] = WDATA; // RQ1
    end
    if (RD && ADDR == stc_pkg::OFF_COUNT_LO && ctrl_reg[stc_pkg::BIT_WIDE])
      hbuf_next = count_reg[15:8]; // RQ5
    if (SPECIAL_EVENT) begin
      count_next = stc_pkg::COUNT_RST; // RQ3
      pre_next   = '0;
    end
  end

  // ==========================================================
  // control, interrupt and read data
  always_comb begin
    ctrl_next = ctrl_reg;
    if (wr_ctl)
      ctrl_next = WDATA;
    ctrl_next[stc_pkg::BIT_SYS_RUN] = SYSCLK_FROM_TIMER_OSC; // RQ6
    mask_next = wr_mk ? WDATA[1:0] : mask_reg;
    stat_next = stat_reg & ~(wr_st ? WDATA[1:0] : 2'h0);
    if (ovf)
      stat_next[stc_pkg::BIT_IRQ_OVF] = 1'b1; // RQ2
    if (SPECIAL_EVENT)
      stat_next[stc_pkg::BIT_IRQ_SET] = 1'b1;
    rdata_next = 8'h00;
    if (RD) begin
      case (ADDR)
        stc_pkg::OFF_CONTROL:  rdata_next = ctrl_reg;
        stc_pkg::OFF_COUNT_LO: rdata_next = count_reg[7:0];
        stc_pkg::OFF_COUNT_HI: rdata_next = ctrl_reg[stc_pkg::BIT_WIDE] ? hbuf_reg
                                                                         : count_reg[15:8];
        stc_pkg::OFF_IRQ_STAT: rdata_next = {6'h00, stat_reg};
        stc_pkg::OFF_IRQ_MASK: rdata_next = {6'h00, mask_reg};
        default:               rdata_next = 8'h00;
      endcase
    end
  end

  // registers
  always_ff @(posedge CLK) begin
    if (!RSTN) begin
      ctrl_reg  <= stc_pkg::CONTROL_RST;
      count_reg <= stc_pkg::COUNT_RST;
      hbuf_reg  <= 8'h00;
      idiv_reg  <= 2'h0;
      pre_reg   <= '0;
      stat_reg  <= stc_pkg::IRQ_RST;
      mask_reg  <= stc_pkg::IRQ_RST;
      rdata_reg <= 8'h00;
    end else begin
      ctrl_reg  <= ctrl_next;
      count_reg <= count_next;
      hbuf_reg  <= hbuf_next;
      idiv_reg  <= idiv_next;
      pre_reg   <= pre_next;
      stat_reg  <= stat_next;
      mask_reg  <= mask_next;
      rdata_reg <= rdata_next;
    end
  end

  // outputs
  assign RDATA            = rdata_reg;
  assign TIMER_OSC_ENABLE = ctrl_reg[stc_pkg::BIT_OSC_EN]; // RQ7
  assign IRQ              = |(stat_reg & mask_reg);
endmodule
`default_nettype wire

// >>> pkg/stc_pkg.sv
// shared constants for the sixteen bit timer counter
package stc_pkg;
  // ==========================================================
  // register offsets (plain port, byte-wide registers)
  localparam logic [3:0] OFF_CONTROL   = 4'h0;
  localparam logic [3:0] OFF_COUNT_LO  = 4'h1;
  localparam logic [3:0] OFF_COUNT_HI  = 4'h2;
  localparam logic [3:0] OFF_IRQ_STAT  = 4'h3;
  localparam logic [3:0] OFF_IRQ_MASK  = 4'h4;
  // ==========================================================
  // control field positions
  localparam int BIT_RUN      = 0;
  localparam int BIT_CLK_SEL  = 1;
  localparam int BIT_SYNC_BYP = 2;
  localparam int BIT_OSC_EN   = 3;
  localparam int BIT_PRE_LO   = 4;
  localparam int BIT_PRE_HI   = 5;
  localparam int BIT_SYS_RUN  = 6;
  localparam int BIT_WIDE     = 7;
  // ==========================================================
  // status bit positions
  localparam int BIT_IRQ_OVF  = 0;
  localparam int BIT_IRQ_SET  = 1;
  // ==========================================================
  // reset values, count maximum and internal divider match
  localparam logic [7:0]  CONTROL_RST = 8'h00;
  localparam logic [15:0] COUNT_RST   = 16'h0000;
  localparam logic [15:0] COUNT_MAX   = 16'hFFFF;
  localparam logic [1:0]  IRQ_RST     = 2'h0;
  localparam logic [1:0]  INT_DIV     = 2'h3;   // internal clock is osc/4
endpackage

// >>> design/stc_edge_sync.sv
// optional two stage synchroniser and rising edge detector for the count pin
`timescale 1ns/100ps
`default_nettype none
module stc_edge_sync (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic pin,
  input  wire logic bypass,
  output logic      rise
);
  logic meta_reg, meta_next;
  logic sync_reg, sync_next;
  logic last_reg, last_next;
  logic samp;

  // next values; bypass skips both synchroniser stages and samples the pin directly for lower latency
  always_comb begin
    meta_next = pin;
    sync_next = meta_reg;
    samp      = bypass ? pin : sync_reg;
    last_next = samp;
    rise      = samp & ~last_reg;
  end

  // registers
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      meta_reg <= 1'b0;
      sync_reg <= 1'b0;
      last_reg <= 1'b0;
    end else begin
      meta_reg <= meta_next;
      sync_reg <= sync_next;
      last_reg <= last_next;
    end
  end
endmodule
`default_nettype wire

// >>> test/stc_timer_monitor.sv
// port checker for the timer counter, bound to its top module
`timescale 1ns/100ps
`default_nettype none
module stc_timer_monitor (
  input wire logic       CLK,
  input wire logic       RSTN,
  input wire logic [3:0] ADDR,
  input wire logic [7:0] WDATA,
  input wire logic       WR,
  input wire logic       RD,
  input wire logic [7:0] RDATA,
  input wire logic       SPECIAL_EVENT,
  input wire logic       SYSCLK_FROM_TIMER_OSC,
  input wire logic       TIMER_OSC_ENABLE,
  input wire logic       IRQ
);
  default clocking @(posedge CLK); endclocking
  default disable iff (!RSTN);
  logic [7:0] ctl_reg;
  logic [7:0] ctl_next;
  // shadow of the last control write
  always_comb ctl_next = (WR && ADDR == stc_pkg::OFF_CONTROL) ? WDATA : ctl_reg;
  always_ff @(posedge CLK) ctl_reg <= RSTN ? ctl_next : stc_pkg::CONTROL_RST;
  a_rd_idle: assert property (!$past(RD) |-> RDATA == 8'h00)
    else $error("read data not idle");
  a_ctl_back: assert property (RD && ADDR == stc_pkg::OFF_CONTROL |=>
    (RDATA & 8'hBF) == ($past(ctl_reg) & 8'hBF)) else $error("control readback");
  a_sys_flag: assert property ($past(RSTN) && RD && ADDR == stc_pkg::OFF_CONTROL |=>
    RDATA[6] == $past(SYSCLK_FROM_TIMER_OSC, 2)) else $error("clock status bit");
  a_osc_out: assert property (TIMER_OSC_ENABLE == ctl_reg[3])
    else $error("oscillator enable");
  a_no_map: assert property (RD && ADDR > stc_pkg::OFF_IRQ_MASK |=> RDATA == 8'h00)
    else $error("unmapped read");
  a_evt_zero: assert property ($past(SPECIAL_EVENT) && RD &&
    ADDR == stc_pkg::OFF_COUNT_LO |=> RDATA == 8'h00) else $error("event clear");
  a_mask_off: assert property (WR && ADDR == stc_pkg::OFF_IRQ_MASK && WDATA == 8'h00
    ##1 !(WR && ADDR == stc_pkg::OFF_IRQ_MASK) |=> !IRQ) else $error("masked irq");
  a_stat_pad: assert property (RD && ADDR == stc_pkg::OFF_IRQ_STAT |=>
    RDATA[7:2] == 6'h00) else $error("status pad");
  c_event: cover property (SPECIAL_EVENT);
  c_irq: cover property (IRQ);
  c_hi: cover property (RD && ADDR == stc_pkg::OFF_COUNT_HI);
endmodule
bind stc_timer stc_timer_monitor stc_timer_monitor_i (.*);
`default_nettype wire

// >>> test/stc_clk_src.sv
// external count source: a requested number of rising edges while enabled
`timescale 1ns/100ps
`default_nettype none
module stc_clk_src (
  input  wire logic       clk,
  input  wire logic       osc_en,
  input  wire logic [7:0] want,
  output logic            pin
);
  logic [2:0] ph_reg = 3'h0;
  logic [7:0] done_reg = 8'h00;
  // one edge per eight cycles, tally cleared while shut down
  always_ff @(posedge clk) begin
    ph_reg <= ph_reg + 3'h1;
    done_reg <= !osc_en ? 8'h00 : done_reg + {7'h00, ph_reg == 3'h7 && done_reg != want};
  end
  // line idles low outside a burst and while off
  assign pin = osc_en && ph_reg[2] && done_reg != want;
endmodule
`default_nettype wire

// >>> test/test_stc_timer.sv
// self-checking bench for the timer counter
`timescale 1ns/100ps
`default_nettype none
module test_stc_timer;
  logic       CLK, RSTN, WR, RD, SPECIAL_EVENT, SYSCLK_FROM_TIMER_OSC;
  logic       EXT_COUNT_PIN, TIMER_OSC_ENABLE, IRQ;
  logic [3:0] ADDR;
  logic [7:0] WDATA, RDATA, want;
  logic [2:0] p;
  int         mismatches, compares;
  stc_timer stc_timer_i (.*);
  stc_clk_src stc_clk_src_i (
    .clk    (CLK),
    .osc_en (TIMER_OSC_ENABLE),
    .want   (want),
    .pin    (EXT_COUNT_PIN)
  );
  task automatic chk(input string n, input logic [7:0] s, input logic [7:0] e);
    compares++;
    if (s !== e) begin
      mismatches++;
      $display("BAD %s exp %h got %h", n, e, s);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge CLK);
    ADDR <= a;
    WDATA <= d;
    WR <= 1'b1;
    @(posedge CLK);
    WR <= 1'b0;
  endtask
  // optional event pulse, then a read right behind it
  task automatic rc(input logic [3:0] a, input logic [7:0] e, input logic ev = 1'b0);
    @(posedge CLK);
    SPECIAL_EVENT <= ev;
    @(posedge CLK);
    SPECIAL_EVENT <= 1'b0;
    ADDR <= a;
    RD <= 1'b1;
    @(posedge CLK);
    RD <= 1'b0;
    #1 chk("rdata", RDATA, e);
  endtask
  task automatic iq(input logic e);
    repeat (2) @(posedge CLK);
    #1 chk("irq", {7'h00, IRQ}, {7'h00, e});
  endtask
  task automatic test_done;
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    CLK = 1'b0;
    forever #2 CLK = ~CLK;
  end
  initial begin
    #40000;
    mismatches++;
    test_done;
  end
  initial begin
    {RSTN, WR, RD, SPECIAL_EVENT, SYSCLK_FROM_TIMER_OSC} = '0;
    {ADDR, WDATA, want} = '0;
    repeat (8) @(posedge CLK);
    RSTN <= 1'b1;
    rc(4'h0, 8'h00);
    wr(4'h0, 8'hFF);
    rc(4'h0, 8'hBF);
    chk("osc", {7'h00, TIMER_OSC_ENABLE}, 8'h01);
    SYSCLK_FROM_TIMER_OSC <= 1'b1;
    rc(4'h0, 8'hFF);
    wr(4'h0, 8'h00);
    #1 chk("osc", {7'h00, TIMER_OSC_ENABLE}, 8'h00);
    wr(4'h1, 8'h34);
    wr(4'h2, 8'h12);
    rc(4'h1, 8'h34);
    rc(4'h2, 8'h12);
    // internal clock rolls the count over
    wr(4'h1, 8'hFE);
    wr(4'h2, 8'hFF);
    wr(4'h4, 8'h01);
    wr(4'h0, 8'h05);
    repeat (20) @(posedge CLK);
    wr(4'h0, 8'h00);
    iq(1'b1);
    rc(4'h3, 8'h01);
    wr(4'h3, 8'h01);
    iq(1'b0);
    // pin bursts of sixteen edges through each prescale, sync and bypass
    for (p = 3'h0; p < 3'h4; p++) begin
      wr(4'h0, {2'b00, p[1:0], 1'b1, p[0], 2'b11});
      rc(4'h1, 8'h00, 1'b1);
      want <= 8'h10;
      repeat (150) @(posedge CLK);
      wr(4'h0, 8'h00);
      want <= 8'h00;
      rc(4'h1, 8'h10 >> p);
    end
    rc(4'h3, 8'h02);
    iq(1'b0);
    wr(4'h4, 8'h02);
    iq(1'b1);
    wr(4'h3, 8'h02);
    iq(1'b0);
    wr(4'h4, 8'h00);
    // wide mode buffers the high byte
    wr(4'h0, 8'h80);
    rc(4'h1, 8'h02);
    rc(4'h2, 8'h00);
    wr(4'h2, 8'hAB);
    wr(4'h1, 8'hCD);
    rc(4'h1, 8'hCD);
    rc(4'h2, 8'hAB);
    // reset again with the counter stopped in wide mode: count and control return to their reset values, bit 6 still follows the clock status
    RSTN <= 1'b0;
    repeat (2) @(posedge CLK);
    RSTN <= 1'b1;
    rc(4'h1, 8'h00);
    rc(4'h0, 8'h40);
    wr(4'hF, 8'h55);
    rc(4'hF, 8'h00);
    test_done;
  end
endmodule
`default_nettype wire
